// ==== shared/ppia_pkg.sv ====
// constants for the four-port power controller interrupt aggregator
package ppia_pkg;
  localparam int DW = 8;
  localparam int NPORT = 4;
  localparam int NEVT = 5;
  localparam int IDXW = 3;

  // command codes
  localparam logic [7:0] CMD_SUMMARY = 8'h00;
  localparam logic [7:0] CMD_ENABLE = 8'h01;
  localparam logic [7:0] CMD_EVT_FIRST = 8'h02;
  localparam logic [7:0] CMD_EVT_LAST = 8'h0B;
  localparam logic [7:0] CMD_GEN_MASK = 8'h17;
  localparam logic [7:0] CMD_RESET = 8'h1A;
  localparam int CLR_LSB = 0;

  // summary and enable bit positions
  localparam int SUP_BIT = 7;
  localparam int STRT_BIT = 6;
  localparam int IFLT_BIT = 5;
  localparam int CLS_BIT = 4;
  localparam int DET_BIT = 3;
  localparam int DIS_BIT = 2;
  localparam int PG_BIT = 1;
  localparam int PE_BIT = 0;

  // event register index, command = CMD_EVT_FIRST + 2*index (+1 clears)
  localparam int EVT_POWER = 0;
  localparam int EVT_DETECT = 1;
  localparam int EVT_FAULT = 2;
  localparam int EVT_START = 3;
  localparam int EVT_SUPPLY = 4;

  // supply event register layout
  localparam int THERM_BIT = 7;
  localparam int LOGIC_UV_BIT = 5;
  localparam int POWER_UV_BIT = 4;

  // other control bits
  localparam int GLOBAL_EN_BIT = 7;
  localparam int RESET_ALL_BIT = 7;

  // reset values
  localparam logic [DW-1:0] EVT_RST = 8'h00;
  localparam logic [DW-1:0] SUPPLY_RST = 8'h30;
  localparam logic [DW-1:0] EN_RST_AUTO = 8'hE4;
  localparam logic [DW-1:0] EN_RST_MANUAL = 8'h80;
  localparam logic [DW-1:0] GEN_MASK_RST = 8'h80;
  localparam logic [DW-1:0] ZERO_BYTE = 8'h00;
endpackage

// ==== logic/ppia_top.sv ====
// interrupt summary, enable, event registers and interrupt pin of the port controller
`timescale 1ns/1ps

// Notes on behaviour
// [R1] summary is a read-only byte at code 00h; writes there change nothing
// [R2] summary bits 7..0: supply, start, current, class, detect, disconnect, pg, pe change
// [R3] clearing read of an event register clears its summary bit; reset bit 7 clears all
// [R4] interrupt asserts when a summary bit and its enable are set and global mask set
// [R5] supply summary is OR of thermal shutdown and both undervoltage flags
// [R6] start summary is OR of the four port start fault flags
// [R7] current summary is OR of four overcurrent cut and four current limit flags
// [R8] class summary is OR of the four port classification cycle flags
// [R9] detect summary is OR of the four port detection cycle flags
// [R10] disconnect summary is OR of the four port disconnect flags
// [R11] power-good summary is OR of the four port power-good change flags
// [R12] power-enable summary is OR of the four port power-enable change flags
// [R13] enable register is read/write at code 01h and reads back stored value
// [R14] enable bits line up with summary bits, bit 7 supply down to bit 0 pe
// [R15] enable one lets its event drive the pin; zero keeps it off the pin
// [R16] summary tracks events whatever the enables hold; masking only gates the pin
// [R17] each event register reads at two codes; the odd one also clears all bits
// [R18] clearing read of the causing register releases the pin unless another source stays
// [R19] interrupt pin is active low, held as a level while any enabled source is set
module ppia_top #(
  parameter bit AUTO_MODE = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // command port from the management bus engine
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [ppia_pkg::DW-1:0] cmd_wdata_i,
  output logic [ppia_pkg::DW-1:0] rdata_o,
  output logic rvalid_o,
  // event set inputs from detection, classification, power and fault logic
  input wire logic [ppia_pkg::NPORT-1:0] port_power_good_change_i,
  input wire logic [ppia_pkg::NPORT-1:0] port_power_enable_change_i,
  input wire logic [ppia_pkg::NPORT-1:0] port_class_cycle_i,
  input wire logic [ppia_pkg::NPORT-1:0] port_detect_cycle_i,
  input wire logic [ppia_pkg::NPORT-1:0] port_disconnect_i,
  input wire logic [ppia_pkg::NPORT-1:0] port_overcurrent_cut_i,
  input wire logic [ppia_pkg::NPORT-1:0] port_current_limit_i,
  input wire logic [ppia_pkg::NPORT-1:0] port_start_fault_i,
  input wire logic thermal_shutdown_event_i,
  input wire logic logic_supply_undervolt_i,
  input wire logic power_supply_undervolt_i,
  // per-port clears from the port state logic
  input wire logic [ppia_pkg::NPORT-1:0] port_turned_off_i,
  input wire logic [ppia_pkg::NPORT-1:0] port_power_off_cmd_i,
  output logic int_n_o
);
  import ppia_pkg::*;

  logic [DW-1:0] evt [NEVT];
  logic [DW-1:0] set_vec [NEVT];
  logic [DW-1:0] port_clr [NEVT];
  logic [DW-1:0] irq_en;
  logic [DW-1:0] gen_mask;
  logic [DW-1:0] summary;
  logic [DW-1:0] supply_set;
  logic [DW-1:0] rd_mux;
  logic [DW-1:0] next_irq_en;
  logic [DW-1:0] next_gen_mask;
  logic [IDXW-1:0] evt_idx;
  logic wr;
  logic rd;
  logic is_evt;
  logic rd_clr;
  logic clr_all;
  logic irq_raw;

  // command decode
  assign wr = cmd_valid_i & cmd_write_i;
  assign rd = cmd_valid_i & ~cmd_write_i;
  assign is_evt = (cmd_code_i >= CMD_EVT_FIRST) && (cmd_code_i <= CMD_EVT_LAST);
  assign evt_idx = IDXW'((cmd_code_i - CMD_EVT_FIRST) >> 1);
  assign rd_clr = rd & is_evt & cmd_code_i[CLR_LSB]; // R17
  // the reset register has no storage; bit 7 acts once and reads back as zero
  assign clr_all = wr & (cmd_code_i == CMD_RESET) & cmd_wdata_i[RESET_ALL_BIT]; // R3

  // set vectors in the documented bit order of each event register
  assign supply_set = (DW'(thermal_shutdown_event_i) << THERM_BIT)
                    | (DW'(logic_supply_undervolt_i) << LOGIC_UV_BIT)
                    | (DW'(power_supply_undervolt_i) << POWER_UV_BIT);
  assign set_vec[EVT_POWER] = {port_power_good_change_i, port_power_enable_change_i};
  assign set_vec[EVT_DETECT] = {port_class_cycle_i, port_detect_cycle_i};
  assign set_vec[EVT_FAULT] = {port_disconnect_i, port_overcurrent_cut_i};
  assign set_vec[EVT_START] = {port_current_limit_i, port_start_fault_i};
  assign set_vec[EVT_SUPPLY] = supply_set;

  // per-port clears: detect bits drop when the port is off,
  // fault and start bits drop on a power-off command
  assign port_clr[EVT_POWER] = ZERO_BYTE;
  assign port_clr[EVT_DETECT] = {port_turned_off_i, port_turned_off_i};
  assign port_clr[EVT_FAULT] = {port_power_off_cmd_i, port_power_off_cmd_i};
  assign port_clr[EVT_START] = {port_power_off_cmd_i, port_power_off_cmd_i};
  assign port_clr[EVT_SUPPLY] = ZERO_BYTE;

  // event registers: a set in the same cycle as any clear wins
  generate
    for (genvar i = 0; i < NEVT; i++) begin : g_evt
      localparam logic [DW-1:0] RST_VAL = (i == EVT_SUPPLY) ? SUPPLY_RST : EVT_RST;
      logic clr_this;
      logic [DW-1:0] clr_mask;
      logic [DW-1:0] next_evt;
      assign clr_this = clr_all | (rd_clr && (evt_idx == IDXW'(i))); // R3 R17 R18
      assign clr_mask = {DW{clr_this}} | port_clr[i];
      assign next_evt = (evt[i] & ~clr_mask) | set_vec[i]; // R16
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          evt[i] <= RST_VAL;
        end else begin
          evt[i] <= next_evt;
        end
      end
    end
  endgenerate

  // summary is derived from the event registers, so it always matches them
  assign summary[SUP_BIT] = |evt[EVT_SUPPLY]; // R5
  assign summary[STRT_BIT] = |evt[EVT_START][NPORT-1:0]; // R6
  assign summary[IFLT_BIT] = (|evt[EVT_START][DW-1:NPORT]) | (|evt[EVT_FAULT][NPORT-1:0]); // R7
  assign summary[CLS_BIT] = |evt[EVT_DETECT][DW-1:NPORT]; // R8
  assign summary[DET_BIT] = |evt[EVT_DETECT][NPORT-1:0]; // R9
  assign summary[DIS_BIT] = |evt[EVT_FAULT][DW-1:NPORT]; // R10
  assign summary[PG_BIT] = |evt[EVT_POWER][DW-1:NPORT]; // R11
  assign summary[PE_BIT] = |evt[EVT_POWER][NPORT-1:0]; // R12 R2

  // writable registers; writes to the summary code fall through untouched
  assign next_irq_en = (wr && cmd_code_i == CMD_ENABLE) ? cmd_wdata_i : irq_en; // R13 R1
  assign next_gen_mask = (wr && cmd_code_i == CMD_GEN_MASK) ? cmd_wdata_i : gen_mask;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_en <= AUTO_MODE ? EN_RST_AUTO : EN_RST_MANUAL;
      gen_mask <= GEN_MASK_RST;
    end else begin
      irq_en <= next_irq_en;
      gen_mask <= next_gen_mask;
    end
  end

  // read path: data is sampled before the clearing read takes effect
  assign rd_mux = (cmd_code_i == CMD_SUMMARY) ? summary :
                  (cmd_code_i == CMD_ENABLE) ? irq_en :
                  (cmd_code_i == CMD_GEN_MASK) ? gen_mask :
                  is_evt ? evt[evt_idx] : ZERO_BYTE; // R1 R13 R17

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= ZERO_BYTE;
      rvalid_o <= 1'b0;
    end else begin
      rdata_o <= rd ? rd_mux : rdata_o;
      rvalid_o <= rd;
    end
  end

  // interrupt pin: registered level, one cycle behind the flags
  assign irq_raw = (|(summary & irq_en)) & gen_mask[GLOBAL_EN_BIT]; // R4 R14 R15

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      int_n_o <= 1'b1;
    end else begin
      int_n_o <= ~irq_raw; // R19
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  logic no_set;
  assign no_set = ~(|set_vec[EVT_POWER] | |set_vec[EVT_DETECT] | |set_vec[EVT_FAULT]
                  | |set_vec[EVT_START] | |set_vec[EVT_SUPPLY]);

  chk_irq_assert: assert property ( // R4
    (|(summary & irq_en)) && gen_mask[GLOBAL_EN_BIT] |=> !int_n_o
  ) else $error("interrupt pin not asserted for enabled source");

  chk_irq_masked_off: assert property ( // R15
    !(|(summary & irq_en)) |=> int_n_o
  ) else $error("interrupt pin asserted with no enabled source");

  chk_global_mask: assert property ( // R19
    !gen_mask[GLOBAL_EN_BIT] |=> int_n_o
  ) else $error("interrupt pin asserted while globally masked");

  chk_summary_ro: assert property ( // R1
    wr && cmd_code_i == CMD_SUMMARY && no_set && !clr_all |=> summary == $past(summary)
  ) else $error("write to summary changed it");

  chk_supply_or: assert property ( // R5
    thermal_shutdown_event_i || logic_supply_undervolt_i || power_supply_undervolt_i
      |=> summary[SUP_BIT]
  ) else $error("supply summary missed an event");

  chk_start_or: assert property ( // R6
    |port_start_fault_i |=> summary[STRT_BIT]
  ) else $error("start summary missed an event");

  chk_current_or: assert property ( // R7
    |(port_overcurrent_cut_i | port_current_limit_i) |=> summary[IFLT_BIT]
  ) else $error("current summary missed an event");

  chk_class_or: assert property ( // R8
    |port_class_cycle_i |=> summary[CLS_BIT]
  ) else $error("class summary missed an event");

  chk_detect_or: assert property ( // R9
    |port_detect_cycle_i |=> summary[DET_BIT]
  ) else $error("detect summary missed an event");

  chk_disc_or: assert property ( // R10
    |port_disconnect_i |=> summary[DIS_BIT]
  ) else $error("disconnect summary missed an event");

  chk_pg_or: assert property ( // R11
    |port_power_good_change_i |=> summary[PG_BIT]
  ) else $error("power-good summary missed an event");

  chk_pe_or: assert property ( // R12
    |port_power_enable_change_i |=> summary[PE_BIT]
  ) else $error("power-enable summary missed an event");

  chk_enable_store: assert property ( // R13
    wr && cmd_code_i == CMD_ENABLE |=> irq_en == $past(cmd_wdata_i)
  ) else $error("enable register did not store write");

  chk_enable_align: assert property ( // R14
    summary[SUP_BIT] && irq_en == (DW'(1) << SUP_BIT) && gen_mask[GLOBAL_EN_BIT] |=> !int_n_o
  ) else $error("supply enable does not gate supply summary");

  chk_capture_masked: assert property ( // R16
    |port_start_fault_i && !irq_en[STRT_BIT] |=> summary[STRT_BIT]
  ) else $error("masked event not captured");

  chk_clr_read: assert property ( // R17
    rd_clr && no_set && port_clr[evt_idx] == ZERO_BYTE
      |=> rvalid_o && rdata_o == $past(evt[evt_idx]) && evt[$past(evt_idx)] == ZERO_BYTE
  ) else $error("clearing read did not return then clear");

  chk_plain_read: assert property ( // R17
    rd && is_evt && !cmd_code_i[CLR_LSB] && no_set |=> evt[$past(evt_idx)] == $past(evt[evt_idx])
  ) else $error("plain read altered event register");

  chk_reset_all: assert property ( // R3
    clr_all && no_set |=> summary == ZERO_BYTE
  ) else $error("reset bit did not clear summary");

  chk_release: assert property ( // R18
    clr_all && no_set |=> ##1 int_n_o
  ) else $error("interrupt pin not released after clear");

  chk_read_answer: assert property ( // R17
    rd |=> rvalid_o
  ) else $error("read answer missing");

  chk_read_quiet: assert property ( // R17
    !rd |=> !rvalid_o
  ) else $error("read answer without a read");

  chk_summary_read: assert property ( // R1
    rd && cmd_code_i == CMD_SUMMARY |=> rdata_o == $past(summary)
  ) else $error("summary read returned wrong data");

  chk_enable_read: assert property ( // R13
    rd && cmd_code_i == CMD_ENABLE |=> rdata_o == $past(irq_en)
  ) else $error("enable read returned wrong data");

  chk_plain_data: assert property ( // R17
    rd && is_evt && !cmd_code_i[CLR_LSB] |=> rdata_o == $past(evt[evt_idx])
  ) else $error("plain read returned wrong data");

  chk_clear_release: assert property ( // R18
    rd_clr && no_set && evt_idx == IDXW'(EVT_SUPPLY) && summary == (DW'(1) << SUP_BIT) |=> ##1 int_n_o
  ) else $error("clearing the only source kept the pin low");

  chk_clear_keeps: assert property ( // R18
    rd_clr && evt_idx == IDXW'(EVT_FAULT) && |evt[EVT_SUPPLY] && irq_en[SUP_BIT] && gen_mask[GLOBAL_EN_BIT]
      |=> ##1 !int_n_o
  ) else $error("pin released while another source stays");

  chk_enable_zero: assert property ( // R15
    irq_en == ZERO_BYTE |=> int_n_o
  ) else $error("pin asserted with every enable clear");

  chk_pin_level: assert property ( // R19
    !int_n_o && (|(summary & irq_en)) && gen_mask[GLOBAL_EN_BIT] |=> !int_n_o
  ) else $error("pin dropped while a source stays enabled");

  chk_capture_idle: assert property ( // R16
    |port_disconnect_i && irq_en == ZERO_BYTE |=> summary[DIS_BIT]
  ) else $error("event lost while all enables clear");

  chk_set_wins: assert property ( // R16
    |(port_turned_off_i & port_detect_cycle_i) |=> summary[DET_BIT]
  ) else $error("port clear beat a detection event");

  chk_reset_read: assert property ( // R3
    rd && cmd_code_i == CMD_RESET |=> rdata_o == ZERO_BYTE
  ) else $error("reset register read back nonzero");

endmodule // ppia_top

// ==== testbench/ppia_host.sv ====
// host model issuing register commands toward the aggregator
`timescale 1ns/1ps
module ppia_host (
  input wire logic clk_i,
  output logic cmd_valid_o,
  output logic cmd_write_o,
  output logic [7:0] cmd_code_o,
  output logic [7:0] cmd_wdata_o,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_code_o = 8'hFF;
    cmd_wdata_o = 8'h5A;
  end

  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    @(posedge clk_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_write_o = 1'b1;
    cmd_code_o = code;
    cmd_wdata_o = data;
    @(posedge clk_i);
    #1;
    cmd_valid_o = 1'b0;
    // released fields show no stale value
    cmd_wdata_o = ~data;
    cmd_code_o = ~code;
  endtask

  task automatic rd(input logic [7:0] code, output logic [7:0] data);
    @(posedge clk_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_write_o = 1'b0;
    cmd_code_o = code;
    @(posedge clk_i);
    #1;
    cmd_valid_o = 1'b0;
    cmd_code_o = ~code;
    // answer is due exactly one cycle after the command edge
    testbench.check({7'h00, rvalid_i}, 8'h01, "read answer");
    data = rdata_i;
  endtask
endmodule // ppia_host

// ==== testbench/testbench.sv ====
// self-checking bench for the interrupt aggregator
`timescale 1ns/1ps
module testbench;
  import ppia_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cmd_valid, cmd_write, rvalid, int_n;
  logic [7:0] cmd_code, cmd_wdata, rdata, d;
  logic [3:0] pg = '0, pe = '0, cls = '0, det = '0, dis = '0, ocut = '0, climit = '0, sfault = '0, p;
  logic therm = 1'b0, lsup_uv = 1'b0, psup_uv = 1'b0;
  logic [3:0] toff = '0, poff = '0;
  int num_errors = 0;
  int checks_done = 0;
  localparam int SBIT [11] = '{PE_BIT, PG_BIT, DIS_BIT, DET_BIT, CLS_BIT, IFLT_BIT, IFLT_BIT, STRT_BIT,
    SUP_BIT, SUP_BIT, SUP_BIT};
  localparam logic [7:0] CCODE [11] = '{8'h03, 8'h03, 8'h07, 8'h05, 8'h05, 8'h07, 8'h09, 8'h09,
    8'h0B, 8'h0B, 8'h0B};
  localparam bit HI [8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  localparam logic [7:0] EVAL [3] = '{8'h80, 8'h20, 8'h10};

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  ppia_host host (.clk_i(clk_i), .cmd_valid_o(cmd_valid), .cmd_write_o(cmd_write), .cmd_code_o(cmd_code),
    .cmd_wdata_o(cmd_wdata), .rdata_i(rdata), .rvalid_i(rvalid));

  ppia_top #(.AUTO_MODE(1'b1)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid),
    .cmd_write_i(cmd_write), .cmd_code_i(cmd_code), .cmd_wdata_i(cmd_wdata), .rdata_o(rdata),
    .rvalid_o(rvalid), .port_power_good_change_i(pg), .port_power_enable_change_i(pe),
    .port_class_cycle_i(cls), .port_detect_cycle_i(det), .port_disconnect_i(dis),
    .port_overcurrent_cut_i(ocut), .port_current_limit_i(climit), .port_start_fault_i(sfault),
    .thermal_shutdown_event_i(therm), .logic_supply_undervolt_i(lsup_uv),
    .power_supply_undervolt_i(psup_uv), .port_turned_off_i(toff), .port_power_off_cmd_i(poff),
    .int_n_o(int_n));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic settle();
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic pulse(input int k);
    @(posedge clk_i);
    #1;
    case (k)
      0: pe = p;
      1: pg = p;
      2: dis = p;
      3: det = p;
      4: cls = p;
      5: ocut = p;
      6: climit = p;
      7: sfault = p;
      8: therm = 1'b1;
      9: lsup_uv = 1'b1;
      default: psup_uv = 1'b1;
    endcase
    @(posedge clk_i);
    #1;
    {pg, pe, cls, det, dis, ocut, climit, sfault} = '0;
    {therm, lsup_uv, psup_uv} = '0;
  endtask

  task automatic sc_reset();
    host.rd(CMD_SUMMARY, d);
    check(d, 8'h80, "summary reset");
    check({7'h00, int_n}, 8'h00, "int after reset");
    host.wr(CMD_SUMMARY, 8'h7F);
    host.rd(CMD_SUMMARY, d);
    check(d, 8'h80, "summary write ignored");
    host.rd(CMD_ENABLE, d);
    check(d, EN_RST_AUTO, "enable reset");
    host.wr(CMD_ENABLE, 8'hFF);
    host.rd(CMD_ENABLE, d);
    check(d, 8'hFF, "enable readback");
    host.rd(8'h0B, d);
    check(d, SUPPLY_RST, "supply clear read");
    settle();
    check({7'h00, int_n}, 8'h01, "int idle");
  endtask

  // each source in turn, on a rotating port, with both read codes of its register
  task automatic sc_events();
    logic [7:0] ev;
    for (int k = 0; k < 11; k++) begin
      p = 4'h1 << (k % 4);
      ev = (k > 7) ? EVAL[k-8] : (HI[k] ? {p, 4'h0} : {4'h0, p});
      pulse(k);
      host.rd(CMD_SUMMARY, d);
      check(d, 8'h01 << SBIT[k], "summary bit");
      check({7'h00, int_n}, 8'h00, "int asserted");
      host.rd(CCODE[k] - 8'h01, d);
      check(d, ev, "plain read");
      host.rd(CCODE[k], d);
      check(d, ev, "clearing read");
      settle();
      check({7'h00, int_n}, 8'h01, "int released");
      host.rd(CMD_SUMMARY, d);
      check(d, 8'h00, "summary cleared");
    end
  endtask

  task automatic sc_mask();
    host.wr(CMD_ENABLE, 8'h00);
    p = 4'h8;
    pulse(2);
    host.rd(CMD_SUMMARY, d);
    check(d, 8'h04, "flag while masked");
    check({7'h00, int_n}, 8'h01, "masked pin");
    host.wr(CMD_ENABLE, 8'hFB);
    settle();
    check({7'h00, int_n}, 8'h01, "other enables");
    host.wr(CMD_ENABLE, 8'h84);
    settle();
    check({7'h00, int_n}, 8'h00, "enabled pin");
    host.wr(CMD_GEN_MASK, 8'h00);
    settle();
    check({7'h00, int_n}, 8'h01, "global mask off");
    host.wr(CMD_GEN_MASK, 8'h80);
    pulse(8);
    host.rd(8'h07, d);
    settle();
    check({7'h00, int_n}, 8'h00, "second source holds");
    host.wr(CMD_RESET, 8'h80);
    host.rd(CMD_SUMMARY, d);
    check(d, 8'h00, "reset register");
    settle();
    check({7'h00, int_n}, 8'h01, "pin after reset reg");
  endtask

  // port clears from the state logic, a set meeting a clear, reset and mask registers
  task automatic sc_clear();
    p = 4'h2;
    pulse(3);
    @(posedge clk_i);
    #1;
    toff = p;
    @(posedge clk_i);
    #1;
    toff = 4'h0;
    host.rd(CMD_SUMMARY, d);
    check(d, 8'h00, "port off clears detect");
    @(posedge clk_i);
    #1;
    det = p;
    toff = p;
    @(posedge clk_i);
    #1;
    det = 4'h0;
    toff = 4'h0;
    pulse(7);
    @(posedge clk_i);
    #1;
    poff = p;
    @(posedge clk_i);
    #1;
    poff = 4'h0;
    host.rd(CMD_SUMMARY, d);
    check(d, 8'h08, "set beats clear, power off clears start");
    host.rd(8'h05, d);
    check(d, {4'h0, p}, "detect kept");
    host.rd(CMD_RESET, d);
    check(d, 8'h00, "reset register reads zero");
    host.rd(CMD_GEN_MASK, d);
    check(d, 8'h80, "global mask readback");
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    settle();
    sc_reset();
    sc_events();
    sc_mask();
    sc_clear();
    conclude();
  end
endmodule // testbench
